// ---- core_pkg.sv ----
// constants, enumerations and carrier structs for the cpu register file,
// stack pointer and interrupt entry logic.
// assumes a single 100 MHz core clock and a synchronous active-low reset.
package core_pkg;

  localparam int          NUM_REGS        = 32;
  localparam int          PC_W            = 13;
  localparam int          NUM_IRQ         = 20;
  localparam logic [4:0]  PTR_A_LO_IDX    = 5'h1A;
  localparam logic [4:0]  PTR_B_LO_IDX    = 5'h1C;
  localparam logic [4:0]  PTR_C_LO_IDX    = 5'h1E;
  localparam logic [15:0] REGMAP_TOP      = 16'h001F;
  localparam logic [15:0] SP_RESET        = 16'h0000;
  localparam logic [7:0]  STATUS_REGISTER_RESET      = 8'h00;
  localparam int          GIE_BIT         = 7;
  localparam logic [5:0]  IO_SP_LO        = 6'h3D;
  localparam logic [5:0]  IO_SP_HI        = 6'h3E;
  localparam logic [5:0]  IO_STATUS       = 6'h3F;
  localparam logic [PC_W-1:0] BOOT_START  = 13'h1C00;
  localparam logic [PC_W-1:0] VEC_STEP    = 13'h0002;
  localparam int          ENTRY_NS        = 40;
  localparam int          CLK_NS          = 10;
  localparam int          ENTRY_CYCLES    = (ENTRY_NS + CLK_NS - 1) / CLK_NS;

  // stack adjustment commands
  typedef enum logic [2:0] {
    SP_NONE = 3'h0,
    SP_PUSH = 3'h1,
    SP_POP  = 3'h2,
    SP_CALL = 3'h3,
    SP_RET  = 3'h4,
    SP_RETURN_FROM_INTERRUPT = 3'h5
  } sp_op_t;

  // pointer access modes
  typedef enum logic [1:0] {
    PTR_DISP = 2'h0,
    PTR_INC  = 2'h1,
    PTR_DEC  = 2'h2
  } ptr_mode_t;

  // port configurations of the register file
  typedef enum logic [1:0] {
    RF_R1W8  = 2'h0,
    RF_R2W8  = 2'h1,
    RF_R2W16 = 2'h2,
    RF_R1W16 = 2'h3
  } rf_cfg_t;

  // interrupt entry sequencer, gray coded along the path
  typedef enum logic [2:0] {
    IE_IDLE = 3'b000,
    IE_PUSH = 3'b001,
    IE_HOLD = 3'b011,
    IE_JUMP = 3'b010
  } ie_state_t;

  typedef struct packed {
    rf_cfg_t    cfg;
    logic [4:0] rd_a;
    logic [4:0] rd_b;
    logic [4:0] wr_idx;
    logic       wr_en;
    logic [15:0] wr_data;
  } rf_req_t;

  typedef struct packed {
    logic        en;
    logic [1:0]  sel;
    ptr_mode_t   mode;
    logic [5:0]  disp;
  } ptr_req_t;

endpackage : core_pkg

// ---- regfile_array.sv ----
// 32 x 8 working register array with two read ports and one write port,
// writes of 16 bits go to an even/odd pair. synchronous write, async read.
// assumes the caller resolves write conflicts between its sources.
`timescale 1ns/1ns
`default_nettype none
module regfile_array #(
  parameter int N = 32
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic [4:0]    rd_a,
  input  wire logic [4:0]    rd_b,
  output logic      [7:0]    q_a,
  output logic      [7:0]    q_a_hi,
  output logic      [7:0]    q_b,
  input  wire logic          we_lo,
  input  wire logic          we_hi,
  input  wire logic [4:0]    wr_idx,
  input  wire logic [15:0]   wr_data,
  output logic      [N*8-1:0] flat
);
  wire  [4:0] hi_idx = {rd_a[4:1], 1'b1};

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_reg
      // one byte variable per entry, so each has exactly one driving process
      logic [7:0] cell_reg;
      wire sel_lo = we_lo && (wr_idx == 5'(g));
      wire sel_hi = we_hi && ({wr_idx[4:1], 1'b1} == 5'(g));
      always_ff @(posedge clk) begin
        if (!resetn) cell_reg <= 8'h00;
        else if (sel_hi) cell_reg <= wr_data[15:8];
        else if (sel_lo) cell_reg <= wr_data[7:0];
      end
      assign flat[g*8 +: 8] = cell_reg;
    end
  endgenerate

  assign q_a    = flat[rd_a*8 +: 8];
  assign q_a_hi = flat[hi_idx*8 +: 8];
  assign q_b    = flat[rd_b*8 +: 8];
endmodule : regfile_array
`default_nettype wire

// ---- cpu_core_regs.sv ----
// cpu register file, pointer pairs, stack pointer and interrupt entry.
// assumes the fetch/decode logic drives one request per clock and holds
// the stack and data spaces outside; clk is the undivided chip clock.
// Operation
// - register file offers 1r/1w8, 2r/1w8, 2r/1w16 and 1r16/1w16 configurations
// - data-space addresses 0x00..0x1F reach the working register of same index
// - registers 26..31 form three 16-bit pointers, even register low byte
// - pointer access supports displacement, post-increment and pre-decrement
// - push lowers stack pointer by one, pop raises it by one
// - call or interrupt entry lowers by two, return raises by two
// - stack pointer is two read/write 8-bit registers resetting to zero
// - core runs directly on chip clock with no division
// - two operands read and result written in one cycle
// - next instruction fetched while current executes
// - interrupt taken only with its enable and global enable set
// - either boot lock setting suppresses interrupts depending on pc
// - vectors at lowest addresses; lower index means higher priority
// - vector relocate bit moves interrupt vectors to boot section
// - boot reset fuse moves reset vector to boot section
// - interrupt entry clears global enable; software may set it to nest
// - return from interrupt sets global enable
// - global enable is bit 7 of status register
// - interrupt entry takes at least four cycles pushing the pc
`timescale 1ns/1ns
`default_nettype none
module cpu_core_regs
  import core_pkg::*;
#(
  parameter int NIRQ = core_pkg::NUM_IRQ
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire core_pkg::rf_req_t       rf_req,
  output logic      [7:0]              op_a,
  output logic      [7:0]              op_b,
  output logic      [15:0]             op_wide,
  input  wire core_pkg::ptr_req_t      ptr_req,
  output logic      [15:0]             ptr_addr,
  input  wire logic                    ds_rd,
  input  wire logic                    ds_wr,
  input  wire logic [15:0]             ds_addr,
  input  wire logic [7:0]              ds_wdata,
  output logic      [7:0]              ds_rdata,
  output logic                         ds_hit,
  input  wire logic                    io_wr,
  input  wire logic [5:0]              io_addr,
  input  wire logic [7:0]              io_wdata,
  output logic      [7:0]              io_rdata,
  input  wire core_pkg::sp_op_t        sp_op,
  output logic      [15:0]             stack_ptr,
  input  wire logic                    gie_set,
  input  wire logic                    gie_clr,
  input  wire logic [NIRQ-1:0]         irq_flag,
  input  wire logic [NIRQ-1:0]         irq_enable,
  input  wire logic                    vector_relocate_bit,
  input  wire logic                    boot_reset_fuse,
  input  wire logic                    app_lock_setting,
  input  wire logic                    boot_lock_setting,
  input  wire logic [PC_W-1:0]         pc,
  input  wire logic                    insn_boundary,
  output logic                         irq_take,
  output logic      [$clog2(NIRQ)-1:0] irq_index,
  output logic                         entry_busy,
  output logic                         entry_push,
  output logic      [PC_W-1:0]         vector_addr,
  output logic      [PC_W-1:0]         reset_vector,
  output logic                         fetch_en,
  output logic      [7:0]              status_reg
);
  import core_pkg::*;

  // register array
  logic [NUM_REGS*8-1:0] flat;
  logic [7:0]  q_a, q_a_hi, q_b;
  logic [4:0]  wr_idx;
  logic [15:0] wr_data;
  logic        we_lo, we_hi;

  // pointer update path
  wire [4:0]  ptr_lo_idx = (ptr_req.sel == 2'd0) ? PTR_A_LO_IDX :
                           (ptr_req.sel == 2'd1) ? PTR_B_LO_IDX : PTR_C_LO_IDX;
  wire [15:0] ptr_val    = {flat[(ptr_lo_idx+1)*8 +: 8], flat[ptr_lo_idx*8 +: 8]};
  wire [15:0] ptr_dec    = ptr_val - 16'h0001;
  wire [15:0] ptr_inc    = ptr_val + 16'h0001;
  wire        ptr_upd    = ptr_req.en && (ptr_req.mode != PTR_DISP);
  wire [15:0] ptr_new    = (ptr_req.mode == PTR_DEC) ? ptr_dec : ptr_inc;

  // pre-decrement uses the new value, post-increment the old
  assign ptr_addr = (ptr_req.mode == PTR_DEC)  ? ptr_dec :
                    (ptr_req.mode == PTR_DISP) ? ptr_val + {10'h000, ptr_req.disp} :
                    ptr_val;

  // data-space window onto the register file
  assign ds_hit = (ds_rd || ds_wr) && (ds_addr <= REGMAP_TOP);
  wire ds_we    = ds_wr && (ds_addr <= REGMAP_TOP);

  wire wide_wr  = rf_req.cfg == RF_R2W16 || rf_req.cfg == RF_R1W16;

  // write source priority: alu result, then data-space store, then pointer update.
  // the decoder never issues two in one cycle; the order only keeps one driver.
  always_comb begin
    wr_idx  = rf_req.wr_idx;
    wr_data = rf_req.wr_data;
    we_lo   = 1'b0;
    we_hi   = 1'b0;
    if (rf_req.wr_en) begin
      we_lo = 1'b1;
      we_hi = wide_wr;
    end else if (ds_we) begin
      wr_idx  = ds_addr[4:0];
      wr_data = {8'h00, ds_wdata};
      we_lo   = 1'b1;
    end else if (ptr_upd) begin
      wr_idx  = ptr_lo_idx;
      wr_data = ptr_new;
      we_lo   = 1'b1;
      we_hi   = 1'b1;
    end
  end

  regfile_array #(.N(NUM_REGS)) u_array (
    .clk     (clk),
    .resetn  (resetn),
    .rd_a    (rf_req.rd_a),
    .rd_b    (rf_req.rd_b),
    .q_a     (q_a),
    .q_a_hi  (q_a_hi),
    .q_b     (q_b),
    .we_lo   (we_lo),
    .we_hi   (we_hi),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .flat    (flat)
  );

  // operands are combinational so the result lands in the same cycle
  assign op_a    = q_a;
  assign op_b    = (rf_req.cfg == RF_R1W8 || rf_req.cfg == RF_R1W16) ? 8'h00 : q_b;
  assign op_wide = {q_a_hi, q_a};

  logic [7:0] ds_rdata_reg;
  always_ff @(posedge clk) begin
    if (!resetn) ds_rdata_reg <= 8'h00;
    else if (ds_rd && ds_addr <= REGMAP_TOP) ds_rdata_reg <= flat[ds_addr[4:0]*8 +: 8];
  end
  assign ds_rdata = ds_rdata_reg;

  // stack pointer
  logic [15:0] sp_reg, sp_next;
  logic [15:0] sp_delta_dn, sp_delta_up;
  logic [15:0] adj_sp;
  assign sp_delta_dn = sp_reg - 16'h0001;
  assign sp_delta_up = sp_reg + 16'h0001;

  always_comb begin
    case (sp_op)
      SP_PUSH: adj_sp = sp_delta_dn;
      SP_POP:  adj_sp = sp_delta_up;
      SP_CALL: adj_sp = sp_reg - 16'h0002;
      SP_RET,
      SP_RETURN_FROM_INTERRUPT: adj_sp = sp_reg + 16'h0002;
      default: adj_sp = sp_reg;
    endcase
  end

  logic entry_start;
  wire entry_sp = entry_start;
  always_comb begin
    sp_next = entry_sp ? sp_reg - 16'h0002 : adj_sp;
    if (io_wr && io_addr == IO_SP_LO) sp_next[7:0]  = io_wdata;
    if (io_wr && io_addr == IO_SP_HI) sp_next[15:8] = io_wdata;
  end

  always_ff @(posedge clk) begin
    if (!resetn) sp_reg <= SP_RESET;
    else sp_reg <= sp_next;
  end
  assign stack_ptr = sp_reg;

  // status register; only the global enable lives here, other flags are alu-side
  logic gie_reg, gie_next;
  always_comb begin
    gie_next = gie_reg;
    if (io_wr && io_addr == IO_STATUS) gie_next = io_wdata[GIE_BIT];
    if (gie_clr) gie_next = 1'b0;
    if (gie_set || sp_op == SP_RETURN_FROM_INTERRUPT) gie_next = 1'b1;
    if (entry_start) gie_next = 1'b0;
  end
  always_ff @(posedge clk) begin
    if (!resetn) gie_reg <= STATUS_REGISTER_RESET[GIE_BIT];
    else gie_reg <= gie_next;
  end
  assign status_reg = {gie_reg, 7'h00};

  assign io_rdata = (io_addr == IO_SP_LO)  ? sp_reg[7:0]  :
                    (io_addr == IO_SP_HI)  ? sp_reg[15:8] :
                    (io_addr == IO_STATUS) ? status_reg   : 8'h00;

  // interrupt arbitration
  logic [NIRQ-1:0] live;
  assign live = irq_flag & irq_enable;

  // lock bits block interrupts while code runs in the protected section
  wire in_boot   = pc >= BOOT_START;
  wire lock_mask = (app_lock_setting && !in_boot) || (boot_lock_setting && in_boot);

  logic [$clog2(NIRQ)-1:0] pick;
  logic                    any;
  always_comb begin
    pick = '0;
    any  = 1'b0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (live[i]) begin
        pick = ($clog2(NIRQ))'(i);
        any  = 1'b1;
      end
    end
  end

  // entry sequencer
  ie_state_t st_reg, st_next;
  logic [2:0] cnt_reg;
  assign entry_start = (st_reg == IE_IDLE) && any && gie_reg && !lock_mask && insn_boundary;

  always_comb begin
    case (st_reg)
      IE_IDLE: st_next = entry_start ? IE_PUSH : IE_IDLE;
      IE_PUSH: st_next = IE_HOLD;
      IE_HOLD: st_next = (cnt_reg == 3'(ENTRY_CYCLES - 1)) ? IE_JUMP : IE_HOLD;
      IE_JUMP: st_next = IE_IDLE;
      default: st_next = IE_IDLE;
    endcase
  end

  logic [PC_W-1:0] vec_reg;
  logic [$clog2(NIRQ)-1:0] idx_reg;
  wire [PC_W-1:0] vec_base = vector_relocate_bit ? BOOT_START : '0;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg  <= IE_IDLE;
      cnt_reg <= 3'h0;
      vec_reg <= '0;
      idx_reg <= '0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= (st_reg == IE_IDLE) ? 3'h0 : cnt_reg + 3'h1;
      if (entry_start) begin
        idx_reg <= pick;
        vec_reg <= vec_base + VEC_STEP * (PC_W'(pick) + PC_W'(1));
      end
    end
  end

  assign irq_take     = entry_start;
  assign irq_index    = idx_reg;
  assign entry_busy   = st_reg != IE_IDLE;
  assign entry_push   = st_reg == IE_PUSH || (st_reg == IE_HOLD && cnt_reg == 3'h1);
  assign vector_addr  = vec_reg;
  assign reset_vector = boot_reset_fuse ? BOOT_START : '0;
  // prefetch runs every cycle outside entry; stalled while the pc is pushed
  assign fetch_en     = !entry_busy;

  // checks
  chk_push_dec1: assert property (@(posedge clk) disable iff (!resetn)
    sp_op == SP_PUSH && !entry_start && !io_wr |=> sp_reg == $past(sp_reg) - 16'h0001)
    else $error("push did not lower sp by one");
  chk_pop_inc1: assert property (@(posedge clk) disable iff (!resetn)
    sp_op == SP_POP && !entry_start && !io_wr |=> sp_reg == $past(sp_reg) + 16'h0001)
    else $error("pop did not raise sp by one");
  chk_call_dec2: assert property (@(posedge clk) disable iff (!resetn)
    (sp_op == SP_CALL || entry_start) && !io_wr |=> sp_reg == $past(sp_reg) - 16'h0002)
    else $error("call did not lower sp by two");
  chk_ret_inc2: assert property (@(posedge clk) disable iff (!resetn)
    (sp_op == SP_RET || sp_op == SP_RETURN_FROM_INTERRUPT) && !entry_start && !io_wr
    |=> sp_reg == $past(sp_reg) + 16'h0002)
    else $error("return did not raise sp by two");
  chk_entry_gie: assert property (@(posedge clk) disable iff (!resetn)
    entry_start |=> !gie_reg)
    else $error("entry left global enable set");
  chk_return_from_interrupt_gie: assert property (@(posedge clk) disable iff (!resetn)
    sp_op == SP_RETURN_FROM_INTERRUPT && !entry_start |=> gie_reg)
    else $error("return_from_interrupt did not set global enable");
  chk_take_gated: assert property (@(posedge clk) disable iff (!resetn)
    irq_take |-> gie_reg && (irq_flag[pick] && irq_enable[pick]) && !lock_mask)
    else $error("interrupt taken while disabled");
  sequence entry_s;
    irq_take ##1 entry_busy[*4];
  endsequence
  chk_entry_len: assert property (@(posedge clk) disable iff (!resetn)
    irq_take |-> entry_s)
    else $error("entry shorter than four cycles");
  chk_ptr_pair: assert property (@(posedge clk) disable iff (!resetn)
    ptr_req.en && ptr_req.mode == PTR_INC && !rf_req.wr_en && !ds_we
    |=> ptr_val == $past(ptr_val) + 16'h0001 || ptr_req.sel != $past(ptr_req.sel))
    else $error("post increment not applied");
endmodule : cpu_core_regs
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for cpu_core_regs: register file, pointers, stack
// pointer and interrupt entry, all driven from the falling clock edge.
// assumes core_pkg is compiled first and the design keeps its NOTES timing.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import core_pkg::*;
  logic              clk, resetn, ds_rd, ds_wr, io_wr, gie_set, gie_clr;
  logic              vreloc, rfuse, alock, block, bnd;
  rf_req_t           rf_req;
  ptr_req_t          ptr_req;
  sp_op_t            sp_op;
  logic [15:0]       ds_addr, op_wide, ptr_addr, stack_ptr;
  logic [7:0]        ds_wdata, io_wdata, op_a, op_b, ds_rdata, io_rdata, status_reg;
  logic [5:0]        io_addr;
  logic [19:0]       irq_flag, irq_enable;
  logic [PC_W-1:0]   pc, vector_addr, reset_vector;
  logic [4:0]        irq_index;
  logic              ds_hit, irq_take, entry_busy, entry_push, fetch_en;
  int                miscompares, check_count;

  cpu_core_regs cpu_core_regs_i (.clk(clk), .resetn(resetn), .rf_req(rf_req), .op_a(op_a),
    .op_b(op_b), .op_wide(op_wide), .ptr_req(ptr_req), .ptr_addr(ptr_addr), .ds_rd(ds_rd),
    .ds_wr(ds_wr), .ds_addr(ds_addr), .ds_wdata(ds_wdata), .ds_rdata(ds_rdata),
    .ds_hit(ds_hit), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .sp_op(sp_op), .stack_ptr(stack_ptr), .gie_set(gie_set),
    .gie_clr(gie_clr), .irq_flag(irq_flag), .irq_enable(irq_enable),
    .vector_relocate_bit(vreloc), .boot_reset_fuse(rfuse), .app_lock_setting(alock),
    .boot_lock_setting(block), .pc(pc), .insn_boundary(bnd), .irq_take(irq_take),
    .irq_index(irq_index), .entry_busy(entry_busy), .entry_push(entry_push),
    .vector_addr(vector_addr), .reset_vector(reset_vector), .fetch_en(fetch_en),
    .status_reg(status_reg));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cyc(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      @(negedge clk);
    end
  endtask : cyc

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic io_w(input logic [5:0] a, input logic [7:0] d);
    io_wr = 1'b1; io_addr = a; io_wdata = d;
    cyc();
    io_wr = 1'b0;
  endtask : io_w

  task automatic rf_w(input rf_cfg_t c, input logic [4:0] i, input logic [15:0] d);
    rf_req.cfg = c; rf_req.wr_idx = i; rf_req.wr_data = d; rf_req.wr_en = 1'b1;
    cyc();
    rf_req.wr_en = 1'b0;
  endtask : rf_w

  task automatic sp_do(input sp_op_t op);
    // an idle edge keeps back-to-back commands apart
    cyc();
    sp_op = op;
    cyc();
    sp_op = SP_NONE;
  endtask : sp_do

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic t_reset;
    chk("sp", SP_RESET, stack_ptr);
    chk("status", 16'h0000, status_reg);
    io_addr = IO_SP_HI;
    #1;
    chk("sp_hi_rd", 16'h0000, io_rdata);
    $display("test reset done");
  endtask : t_reset

  task automatic t_stack;
    io_w(IO_SP_HI, 8'h04);
    cyc();
    io_w(IO_SP_LO, 8'h5F);
    chk("sp_load", 16'h045F, stack_ptr);
    io_addr = IO_SP_LO;
    chk("sp_lo_rd", 16'h005F, io_rdata);
    sp_do(SP_PUSH);
    chk("push", 16'h045E, stack_ptr);
    sp_do(SP_CALL);
    chk("call", 16'h045C, stack_ptr);
    sp_do(SP_POP);
    chk("pop", 16'h045D, stack_ptr);
    sp_do(SP_RET);
    chk("ret", 16'h045F, stack_ptr);
    $display("test stack done");
  endtask : t_stack

  task automatic t_regs;
    rf_w(RF_R2W8, 5'h03, 16'h00A5);
    cyc();
    rf_w(RF_R2W8, 5'h04, 16'h003C);
    rf_req.cfg = RF_R2W8; rf_req.rd_a = 5'h03; rf_req.rd_b = 5'h04;
    #1;
    chk("op_a", 16'h00A5, op_a);
    chk("op_b", 16'h003C, op_b);
    rf_req.cfg = RF_R1W8;
    #1;
    chk("op_b_single", 16'h0000, op_b);
    ds_addr = 16'h0003; ds_rd = 1'b1;
    #1;
    chk("ds_hit", 16'h0001, ds_hit);
    cyc();
    chk("ds_rdata", 16'h00A5, ds_rdata);
    // read strobe still high, so only the address decides the miss
    ds_addr = 16'h0020;
    #1;
    chk("ds_miss", 16'h0000, ds_hit);
    ds_rd = 1'b0; ds_addr = 16'h001F; ds_wdata = 8'h77; ds_wr = 1'b1;
    cyc();
    ds_wr = 1'b0; rf_req.rd_a = 5'h1F;
    #1;
    chk("ds_wr_top", 16'h0077, op_a);
    rf_w(RF_R2W16, PTR_A_LO_IDX, 16'h1234);
    rf_req.cfg = RF_R1W16; rf_req.rd_a = PTR_A_LO_IDX;
    #1;
    chk("wide", 16'h1234, op_wide);
    rf_req.cfg = RF_R2W8; rf_req.rd_a = 5'h1B;
    #1;
    chk("ptr_a_hi", 16'h0012, op_a);
    $display("test regs done");
  endtask : t_regs

  task automatic t_ptr;
    ptr_req = '{en: 1'b1, sel: 2'd0, mode: PTR_DISP, disp: 6'h3F};
    #1;
    chk("disp", 16'h1273, ptr_addr);
    ptr_req.mode = PTR_INC;
    #1;
    chk("inc_addr", 16'h1234, ptr_addr);
    cyc();
    ptr_req.mode = PTR_DEC;
    #1;
    chk("dec_addr", 16'h1234, ptr_addr);
    cyc();
    rf_w(RF_R2W16, PTR_C_LO_IDX, 16'h00FF);
    ptr_req.sel = 2'd2; ptr_req.mode = PTR_INC;
    cyc();
    ptr_req.en = 1'b0; rf_req.cfg = RF_R1W16;
    rf_req.rd_a = PTR_A_LO_IDX;
    #1;
    chk("ptr_a_after", 16'h1234, op_wide);
    rf_req.rd_a = PTR_C_LO_IDX;
    #1;
    chk("ptr_c_carry", 16'h0100, op_wide);
    $display("test pointers done");
  endtask : t_ptr

  // one entry from flags already applied; checks index, vector and timing
  task automatic entry(input logic [4:0] idx, input logic [15:0] vec, input logic [15:0] sp);
    int n;
    chk("take", 16'h0001, irq_take);
    cyc();
    irq_flag = '0; bnd = 1'b0; n = 0;
    chk("index", idx, irq_index);
    chk("vector", vec, vector_addr);
    chk("gie_cleared", 16'h0000, status_reg);
    chk("sp_entry", sp, stack_ptr);
    chk("fetch_hold", 16'h0000, fetch_en);
    chk("push_on", 16'h0001, entry_push);
    while (entry_busy === 1'b1 && n < 12) begin
      n++;
      cyc();
    end
    chk("entry_long", 16'h0001, n >= 4 && n < 12);
    bnd = 1'b1;
  endtask : entry

  task automatic t_irq;
    cyc();
    rfuse = 1'b1;
    #1;
    chk("reset_vec", BOOT_START, reset_vector);
    rfuse = 1'b0;
    #1;
    chk("reset_vec0", 16'h0000, reset_vector);
    irq_enable = 20'h00028; irq_flag = 20'h00028; bnd = 1'b1;
    #1;
    chk("no_gie", 16'h0000, irq_take);
    gie_set = 1'b1;
    cyc();
    gie_set = 1'b0;
    chk("gie_set", 16'h0080, status_reg);
    entry(5'd3, 16'h0008, 16'h045D);
    sp_do(SP_RETURN_FROM_INTERRUPT);
    chk("return_from_interrupt_sp", 16'h045F, stack_ptr);
    chk("return_from_interrupt_gie", 16'h0080, status_reg);
    vreloc = 1'b1; irq_enable = 20'h00020; irq_flag = 20'h00028;
    #1;
    entry(5'd5, BOOT_START + 16'h000C, 16'h045D);
    gie_set = 1'b1;
    cyc();
    gie_set = 1'b0; alock = 1'b1; pc = '0; irq_flag = 20'h00020;
    #1;
    chk("app_locked", 16'h0000, irq_take);
    pc = BOOT_START;
    #1;
    chk("app_unlocked", 16'h0001, irq_take);
    alock = 1'b0; block = 1'b1;
    #1;
    chk("boot_locked", 16'h0000, irq_take);
    block = 1'b0; irq_flag = '0; gie_clr = 1'b1;
    cyc();
    gie_clr = 1'b0;
    chk("gie_clr", 16'h0000, status_reg);
    $display("test interrupts done");
  endtask : t_irq

  initial begin
    miscompares = 0; check_count = 0;
    resetn = 1'b0; ds_rd = 1'b0; ds_wr = 1'b0; io_wr = 1'b0; gie_set = 1'b0;
    gie_clr = 1'b0; vreloc = 1'b0; rfuse = 1'b0; alock = 1'b0; block = 1'b0;
    bnd = 1'b0; rf_req = '0; ptr_req = '0; sp_op = SP_NONE; ds_addr = '0;
    ds_wdata = '0; io_wdata = '0; io_addr = '0; irq_flag = '0; irq_enable = '0;
    pc = '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_stack();
    t_regs();
    t_ptr();
    t_irq();
    complete_run();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
